/* File: core/fault_protection_pkg.sv */
// fault protection package: register map, field layout, timing and current tables
// assumes one 100 MHz mclk and a single AHB-Lite master
package fault_protection_pkg;
	localparam int NUM_OUT = 4;
	localparam int CLK_MHZ = 100;
	localparam int STARTUP_TIME_US = 50;
	localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLK_MHZ;
	localparam int AUTO_RETRY_CYCLES = 100000;
	localparam int RETRY_LIMIT = 16;
	localparam int INRUSH_STEP_CYCLES = 1000;
	localparam int COOL_UNIT_SHIFT = 10;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OCCFG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RETRY = 8'h0c;
	localparam logic [31:0] CTRL_RESET = 32'h0;
	localparam logic [8:0] OCCFG_RESET = 9'h0;
	localparam int CTRL_ON_LSB = 0;
	localparam int CTRL_DIRDIS_LSB = 4;
	localparam int CTRL_PWM_BIT = 8;
	localparam int CTRL_OVOFF_BIT = 9;
	localparam int CTRL_RETRYDIS_BIT = 10;
	localparam int CTRL_PROF_LSB = 16;
	localparam int OCCFG_SLOPE_LSB = 0;
	localparam int OCCFG_HIGHREM_BIT = 2;
	localparam int OCCFG_DCSEL_LSB = 3;
	localparam int OCCFG_COOL_BIT = 5;
	localparam int OCCFG_COOLSLOPE_LSB = 6;
	localparam int STAT_OT_LSB = 0;
	localparam int STAT_OC_LSB = 4;
	localparam int STAT_SC_LSB = 8;
	localparam int STAT_OVF_BIT = 12;
	localparam int STAT_UVF_BIT = 13;
	localparam int STAT_NORMAL_BIT = 14;
	localparam int STAT_PIN_BIT = 15;
	localparam int STAT_LATCH_LSB = 16;
	localparam int STAT_OUT_LSB = 20;
	localparam int STAT_READY_BIT = 24;
	// ----------------------------------------
	// current profiles, step 0 is the rightmost byte
	// ----------------------------------------
	localparam logic [1:0] PROFILE_HID = 2'h0;
	localparam logic [1:0] PROFILE_55W = 2'h1;
	localparam logic [1:0] PROFILE_28W = 2'h2;
	localparam logic [6:0][7:0] HID_STEPS = {8'h30, 8'h38, 8'h40, 8'h50, 8'h60, 8'h80, 8'hc0};
	localparam logic [6:0][7:0] BULB55_STEPS = {8'h28, 8'h30, 8'h40, 8'h58, 8'h78, 8'ha0, 8'he0};
	localparam logic [6:0][7:0] BULB28_STEPS = {8'h18, 8'h20, 8'h28, 8'h38, 8'h48, 8'h60, 8'h90};
	// index is the dc select code: level two, one, three, four
	localparam logic [3:0][7:0] DC_LEVELS = {8'h20, 8'h1c, 8'h14, 8'h18};
endpackage

/* File: core/overcurrent_profile.sv */
// overcurrent profile of one output: inrush steps then a dc level
// assumes start is a one-cycle pulse and outputOn is the registered switch state
`timescale 1ns/10ps
`default_nettype none
module overcurrent_profile #(
	parameter int STEP_CYCLES = fault_protection_pkg::INRUSH_STEP_CYCLES
)(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic start,
	input wire logic outputOn,
	input wire logic [1:0] profileSel,
	input wire logic [1:0] slopeSel,
	input wire logic highStepRemove,
	input wire logic [1:0] dcLevelSel,
	input wire logic coolingOn,
	input wire logic [1:0] coolingSlope,
	output logic [7:0] level
);
	import fault_protection_pkg::*;

	typedef struct packed {
		logic [2:0] step;
		logic [31:0] stepCnt;
		logic [15:0] offCnt;
	} prof_type;

	prof_type s, next_s;
	logic [15:0] offUnits;
	logic [2:0] firstStep;
	logic [31:0] stepLen;
	logic [6:0][7:0] row;

	always_comb begin
		next_s = s;
		stepLen = 32'(STEP_CYCLES) << slopeSel;
		offUnits = s.offCnt >> (COOL_UNIT_SHIFT + int'(coolingSlope));
		firstStep = highStepRemove ? 3'h1 : 3'h0;
		// a short off time leaves the filament warm, so a lower step suffices
		if (coolingOn && offUnits < 16'h6 && (3'h6 - offUnits[2:0]) > firstStep) begin
			firstStep = 3'h6 - offUnits[2:0];
		end
		if (outputOn) begin
			next_s.offCnt = '0;
		end else if (s.offCnt != 16'hffff) begin
			next_s.offCnt = s.offCnt + 16'h1;
		end
		if (start) begin
			next_s.step = firstStep;
			next_s.stepCnt = '0;
		end else if (s.step != 3'h7) begin
			if (s.stepCnt >= stepLen - 32'h1) begin
				next_s.step = s.step + 3'h1;
				next_s.stepCnt = '0;
			end else begin
				next_s.stepCnt = s.stepCnt + 32'h1;
			end
		end
	end

	always_comb begin
		case (profileSel)
			PROFILE_55W: row = BULB55_STEPS;
			PROFILE_28W: row = BULB28_STEPS;
			default: row = HID_STEPS;
		endcase
		// the first on cycle must already see the inrush step, not the stale dc level
		if (start) begin
			level = row[firstStep];
		end else begin
			level = (s.step == 3'h7) ? DC_LEVELS[dcLevelSel] : row[s.step];
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.step <= 3'h7;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

/* File: core/fault_protection_autoretry.sv */
// fault protection and autoretry for four high-side outputs, AHB-Lite slave
// assumes comparator and supply inputs are already synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module fault_protection_autoretry #(
	parameter int STARTUP_LEN = fault_protection_pkg::STARTUP_CYCLES,
	parameter int RETRY_LEN = fault_protection_pkg::AUTO_RETRY_CYCLES,
	parameter int STEP_LEN = fault_protection_pkg::INRUSH_STEP_CYCLES
)(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic wakeResetPin,
	input wire logic failSafe,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0] directInputs,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0] overTemp,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0][7:0] loadCurrent,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0] severeShort,
	input wire logic vpwrOverVoltage,
	input wire logic vpwrOverRecovered,
	input wire logic vpwrUnder,
	input wire logic vddFail,
	input wire logic supplyPor,
	input wire logic faultStatusPinIn,
	output logic faultStatusPinOut,
	output logic faultStatusPinOe,
	output logic [fault_protection_pkg::NUM_OUT-1:0] switchOutputs,
	output logic normalMode
);
	import fault_protection_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {ST_SLEEP, ST_START, ST_RUN} run_state_type;

	typedef struct packed {
		run_state_type st;
		logic [31:0] startCnt;
		logic [31:0] ctrl;
		logic [8:0] occfg;
		logic [NUM_OUT-1:0] ot;
		logic [NUM_OUT-1:0] oc;
		logic [NUM_OUT-1:0] sc;
		logic ovf;
		logic uvf;
		logic ovActive;
		logic [NUM_OUT-1:0] latchRetry;
		logic [NUM_OUT-1:0] latchShort;
		logic [NUM_OUT-1:0] retryMode;
		logic [NUM_OUT-1:0] prevCmd;
		logic [NUM_OUT-1:0] out;
		logic [NUM_OUT-1:0] inrushStart;
		logic [NUM_OUT-1:0][4:0] retryCnt;
		logic [NUM_OUT-1:0][31:0] retryTimer;
		logic prevWake;
		logic prevFail;
		logic pinOe;
		logic pinData;
		logic normal;
		logic wrPend;
		logic [7:0] wrAddr;
		logic [31:0] rdata;
		logic readyOut;
		logic respOut;
	} state_type;

	state_type s, next_s;

	logic [NUM_OUT-1:0] cmd;
	logic [NUM_OUT-1:0] coolEn;
	logic [NUM_OUT-1:0][7:0] ocLevel;
	logic [31:0] statusWord;
	logic [31:0] rdMux;
	logic addrPhase;
	logic readClr;
	logic running;
	logic ovEnable;
	logic ovShut;
	logic supplyReset;
	logic modeChange;
	logic pwmEn;

	assign pwmEn = s.ctrl[CTRL_PWM_BIT];
	assign running = (s.st == ST_RUN);

	// fault clear command per output, also used as the on command
	assign cmd = (directInputs & ~s.ctrl[CTRL_DIRDIS_LSB +: NUM_OUT] & {NUM_OUT{~pwmEn}})
		| s.ctrl[CTRL_ON_LSB +: NUM_OUT];

	// ----------------------------------------
	// current profiles
	// ----------------------------------------
	for (genvar g = 0; g < NUM_OUT; g++) begin : gen_prof
		logic [1:0] prof;
		assign prof = s.ctrl[CTRL_PROF_LSB + 2 * g +: 2];
		assign coolEn[g] = running && !failSafe && pwmEn && s.occfg[OCCFG_COOL_BIT]
			&& prof == PROFILE_HID;
		// a retry runs the inrush with default slope and all steps
		overcurrent_profile #(
			.STEP_CYCLES(STEP_LEN)
		) u_prof (
			.mclk(mclk),
			.resetn(resetn),
			.start(s.inrushStart[g]),
			.outputOn(s.out[g]),
			.profileSel(prof),
			.slopeSel(s.retryMode[g] ? 2'h0 : s.occfg[OCCFG_SLOPE_LSB +: 2]),
			.highStepRemove(s.retryMode[g] ? 1'b0 : s.occfg[OCCFG_HIGHREM_BIT]),
			.dcLevelSel(s.occfg[OCCFG_DCSEL_LSB +: 2]),
			.coolingOn(coolEn[g]),
			.coolingSlope(s.occfg[OCCFG_COOLSLOPE_LSB +: 2]),
			.level(ocLevel[g])
		);
	end

	// ----------------------------------------
	// register read view
	// ----------------------------------------
	always_comb begin
		statusWord = '0;
		statusWord[STAT_OT_LSB +: NUM_OUT] = s.ot;
		statusWord[STAT_OC_LSB +: NUM_OUT] = s.oc;
		statusWord[STAT_SC_LSB +: NUM_OUT] = s.sc;
		statusWord[STAT_OVF_BIT] = s.ovf;
		statusWord[STAT_UVF_BIT] = s.uvf;
		statusWord[STAT_NORMAL_BIT] = s.normal;
		statusWord[STAT_PIN_BIT] = faultStatusPinIn;
		statusWord[STAT_LATCH_LSB +: NUM_OUT] = s.latchRetry | s.latchShort;
		statusWord[STAT_OUT_LSB +: NUM_OUT] = s.out;
		statusWord[STAT_READY_BIT] = running;
		case (haddr[7:0])
			ADDR_CTRL: rdMux = s.ctrl;
			ADDR_OCCFG: rdMux = {23'h0, s.occfg};
			ADDR_STATUS: rdMux = statusWord;
			ADDR_RETRY: rdMux = {12'h0, s.retryCnt};
			default: rdMux = '0;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.inrushStart = '0;
		addrPhase = hsel && htrans[1] && hready;
		readClr = 1'b0;
		supplyReset = (vddFail && !vpwrUnder) || supplyPor;
		modeChange = (failSafe != s.prevFail);

		// bus: read data is sampled in the address phase so the data
		// phase needs no wait state; writes land in the data phase
		if (addrPhase && !hwrite) begin
			next_s.rdata = rdMux;
			readClr = (haddr[7:0] == ADDR_STATUS);
		end
		next_s.wrPend = addrPhase && hwrite;
		next_s.wrAddr = haddr[7:0];
		// fail-safe keeps default settings, so writes are dropped there
		if (s.wrPend && !failSafe) begin
			if (s.wrAddr == ADDR_CTRL) begin
				next_s.ctrl = hwdata;
			end else if (s.wrAddr == ADDR_OCCFG) begin
				next_s.occfg = hwdata[8:0];
			end
		end

		// clear on read first so that an event of the same cycle wins
		if (readClr) begin
			next_s.ot = '0;
			next_s.oc = '0;
			next_s.sc = '0;
			next_s.ovf = 1'b0;
			next_s.uvf = 1'b0;
		end

		// startup
		next_s.prevWake = wakeResetPin;
		if (wakeResetPin && !s.prevWake && !vpwrUnder && !vddFail) begin
			next_s.st = ST_START;
			next_s.startCnt = '0;
			next_s.ctrl = CTRL_RESET;
			next_s.occfg = OCCFG_RESET;
			next_s.uvf = 1'b1;
		end else if (s.st == ST_START) begin
			if (s.startCnt >= 32'(STARTUP_LEN - 1)) begin
				next_s.st = ST_RUN;
			end else begin
				next_s.startCnt = s.startCnt + 32'h1;
			end
		end

		// mode change and retry disable toggle restart the retry budget
		next_s.prevFail = failSafe;
		if (modeChange) begin
			next_s.retryCnt = '0;
			if (failSafe) begin
				next_s.ctrl = CTRL_RESET;
				next_s.occfg = OCCFG_RESET;
			end
		end
		if (next_s.ctrl[CTRL_RETRYDIS_BIT] != s.ctrl[CTRL_RETRYDIS_BIT]) begin
			next_s.retryCnt = '0;
		end

		// overvoltage with hysteresis
		if (vpwrOverVoltage) begin
			next_s.ovActive = 1'b1;
		end else if (vpwrOverRecovered) begin
			next_s.ovActive = 1'b0;
		end
		ovEnable = failSafe ? wakeResetPin : !s.ctrl[CTRL_OVOFF_BIT];
		ovShut = ovEnable && next_s.ovActive;
		if (vpwrOverVoltage) begin
			// a warning stays set through a read while the condition lasts
			next_s.ovf = 1'b1;
		end
		if (vpwrUnder) begin
			next_s.uvf = 1'b1;
		end

		// per-output protection
		for (int i = 0; i < NUM_OUT; i++) begin
			// releases first, so an overtemperature or undervoltage still present relatches at once
			if (cmd[i] && !s.prevCmd[i]) begin
				next_s.latchRetry[i] = 1'b0;
				next_s.latchShort[i] = 1'b0;
				next_s.retryMode[i] = 1'b0;
				next_s.retryTimer[i] = '0;
				next_s.inrushStart[i] = 1'b1;
			end else if (running && s.latchRetry[i] && !s.latchShort[i]
				&& !s.ctrl[CTRL_RETRYDIS_BIT] && s.retryCnt[i] < 5'(RETRY_LIMIT)
				&& !overTemp[i] && !vpwrUnder) begin
				if (s.retryTimer[i] >= 32'(RETRY_LEN - 1)) begin
					next_s.latchRetry[i] = 1'b0;
					next_s.retryCnt[i] = s.retryCnt[i] + 5'h1;
					next_s.retryMode[i] = 1'b1;
					next_s.retryTimer[i] = '0;
					next_s.inrushStart[i] = 1'b1;
				end else begin
					next_s.retryTimer[i] = s.retryTimer[i] + 32'h1;
				end
			end else begin
				next_s.retryTimer[i] = '0;
			end

			if (overTemp[i]) begin
				next_s.ot[i] = 1'b1;
				if (cmd[i]) begin
					next_s.latchRetry[i] = 1'b1;
				end
			end
			if (s.out[i] && loadCurrent[i] >= ocLevel[i]) begin
				next_s.oc[i] = 1'b1;
				next_s.latchRetry[i] = 1'b1;
			end
			if (s.out[i] && severeShort[i]) begin
				next_s.sc[i] = 1'b1;
				next_s.latchShort[i] = 1'b1;
			end
			if (vpwrUnder && cmd[i]) begin
				next_s.latchRetry[i] = 1'b1;
			end

			if (supplyReset || modeChange) begin
				next_s.latchRetry[i] = 1'b0;
				next_s.latchShort[i] = 1'b0;
				next_s.retryMode[i] = 1'b0;
			end

			next_s.out[i] = running && cmd[i] && !next_s.latchRetry[i]
				&& !next_s.latchShort[i] && !ovShut && !vpwrUnder;
		end
		next_s.prevCmd = cmd;

		// the pin follows live conditions except where a latch holds it
		next_s.pinOe = (s.st != ST_SLEEP)
			&& ((|next_s.latchRetry) || (|next_s.latchShort)
			|| (|overTemp) || ovShut || vpwrUnder);
		next_s.pinData = 1'b0;
		next_s.normal = running && !failSafe;
		next_s.readyOut = 1'b1;
		next_s.respOut = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.readyOut <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hrdata = s.rdata;
	assign hreadyout = s.readyOut;
	assign hresp = s.respOut;
	assign faultStatusPinOut = s.pinData;
	assign faultStatusPinOe = s.pinOe;
	assign switchOutputs = s.out;
	assign normalMode = s.normal;
endmodule
`default_nettype wire

/* File: test/fault_pin_host.sv */
// host side of the open-drain fault pin: the board pull-up and the sensing input
// assumes the device only ever pulls the pin low while its enable is high
`timescale 1ns/10ps
`default_nettype none
module fault_pin_host (
	input wire logic pinOe,
	input wire logic pinOut,
	output logic pinLevel
);
	// released pin floats up to the pull-up, never holds the last driven value
	assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule
`default_nettype wire

/* File: test/fault_protection_autoretry_properties.sv */
// protection timing checker, sees only the top module ports
// assumes one mclk domain and synchronous active-low resetn
`timescale 1ns/10ps
`default_nettype none
module fault_protection_autoretry_properties
	import fault_protection_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic wakeResetPin,
	input wire logic failSafe,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0] directInputs,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0] overTemp,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0][7:0] loadCurrent,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0] severeShort,
	input wire logic vpwrOverVoltage,
	input wire logic vpwrUnder,
	input wire logic faultStatusPinOe,
	input wire logic [fault_protection_pkg::NUM_OUT-1:0] switchOutputs,
	input wire logic normalMode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence otTrip;
		overTemp[0] && switchOutputs[0];
	endsequence
	sequence scTrip;
		severeShort[3] && switchOutputs[3];
	endsequence
	a_ot_latch_off: assert property (otTrip |-> ##[1:2] (!switchOutputs[0] && faultStatusPinOe))
		else $error("overtemperature did not latch output off");
	a_oc_latch_off: assert property (loadCurrent[2] == 8'hff && switchOutputs[2] |-> ##[1:2] !switchOutputs[2])
		else $error("overcurrent did not turn output off");
	a_short_latch_off: assert property (scTrip |-> ##[1:2] (!switchOutputs[3] && faultStatusPinOe))
		else $error("severe short did not latch output off");
	a_uv_outputs_off: assert property (vpwrUnder |=> switchOutputs == 4'h0)
		else $error("output on during undervoltage");
	a_uv_pin_low: assert property (vpwrUnder && normalMode |-> ##[1:2] faultStatusPinOe)
		else $error("fault pin released during undervoltage");
	a_ov_failsafe_off: assert property (failSafe && wakeResetPin && vpwrOverVoltage |-> ##[1:2] switchOutputs == 4'h0)
		else $error("fail-safe overvoltage left an output on");
	a_failsafe_follow: assert property (failSafe && $past(failSafe) && !directInputs[1] |=> !switchOutputs[1])
		else $error("fail-safe output on without its input");
	a_sleep_dark: assert property ($rose(resetn) |-> (switchOutputs == 4'h0 && !faultStatusPinOe)[*2])
		else $error("activity before wake");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
endmodule
bind fault_protection_autoretry fault_protection_autoretry_properties chk (.mclk(mclk), .resetn(resetn),
	.hreadyout(hreadyout), .hresp(hresp), .wakeResetPin(wakeResetPin), .failSafe(failSafe),
	.directInputs(directInputs), .overTemp(overTemp), .loadCurrent(loadCurrent), .severeShort(severeShort),
	.vpwrOverVoltage(vpwrOverVoltage), .vpwrUnder(vpwrUnder), .faultStatusPinOe(faultStatusPinOe),
	.switchOutputs(switchOutputs), .normalMode(normalMode));
`default_nettype wire

/* File: test/fault_protection_autoretry_test.sv */
// self-checking bench for the fault protection block
// assumes the package is compiled first and the fault pin pull-up sits in the pin model
`timescale 1ns/10ps
`default_nettype none
module fault_protection_autoretry_test;
	import fault_protection_pkg::*;
	logic mclk, resetn, hsel, hwrite, hreadyout, hresp, wakeResetPin, failSafe, pinLevel, pinOut, pinOe;
	logic vpwrOverVoltage, vpwrOverRecovered, vpwrUnder, vddFail, supplyPor, normalMode;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [NUM_OUT-1:0] directInputs, overTemp, severeShort, switchOutputs;
	logic [NUM_OUT-1:0][7:0] loadCurrent;
	logic [15:0] lfsr;
	int nFail, samplesChecked;
	// short counts keep the run small; the waits below are fixed cycle counts sized by hand to them
	fault_protection_autoretry #(.STARTUP_LEN(20), .RETRY_LEN(50), .STEP_LEN(4)) uut (.mclk(mclk), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wakeResetPin(wakeResetPin),
		.failSafe(failSafe), .directInputs(directInputs), .overTemp(overTemp), .loadCurrent(loadCurrent),
		.severeShort(severeShort), .vpwrOverVoltage(vpwrOverVoltage), .vpwrOverRecovered(vpwrOverRecovered),
		.vpwrUnder(vpwrUnder), .vddFail(vddFail), .supplyPor(supplyPor), .faultStatusPinIn(pinLevel),
		.faultStatusPinOut(pinOut), .faultStatusPinOe(pinOe), .switchOutputs(switchOutputs), .normalMode(normalMode));
	fault_pin_host pin (.pinOe(pinOe), .pinOut(pinOut), .pinLevel(pinLevel));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] expOut(input logic [3:0] on, input logic [3:0] dis, input logic [3:0] dir);
		return {28'h0, (dir & ~dis) | on};
	endfunction
	task automatic testDone();
		$display("checks %0d mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nFail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic waitReady();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			nFail++;
			testDone();
		end
	endtask
	// entered just after a rising edge; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
		rd = hrdata;
	endtask
	task automatic sw(input logic [3:0] exp);
		check({28'h0, switchOutputs}, {28'h0, exp});
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{resetn, hsel, hwrite, wakeResetPin, failSafe, vpwrOverVoltage, vpwrUnder, vddFail, supplyPor} = '0;
		vpwrOverRecovered = 1'b1;
		{haddr, hwdata, htrans, hsize, directInputs, overTemp, severeShort, loadCurrent} = '0;
		{nFail, samplesChecked} = '0;
		lfsr = 16'h0019;
		cycles(4);
		resetn <= 1'b1;
		cycles(3);
		sw(4'h0);
		wakeResetPin <= 1'b1; // pwm stays off, so no reference clock is owed on input zero
		cycles(30);
		check({31'h0, normalMode}, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h0);
		bus(1'b0, ADDR_CTRL, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[STAT_UVF_BIT]}, 32'h1);
		check({31'h0, rd[STAT_READY_BIT]}, 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({18'h0, rd[13:0]}, 32'h0);
		$display("end wake");
		for (int k = 0; k < 6; k++) begin
			lfsr = lfsrNext(lfsr);
			directInputs <= lfsr[11:8];
			bus(1'b1, ADDR_CTRL, {24'h0, lfsr[7:0]});
			cycles(3);
			check({28'h0, switchOutputs}, expOut(lfsr[3:0], lfsr[7:4], lfsr[11:8]));
		end
		directInputs <= 4'h0;
		$display("end command");
		bus(1'b1, ADDR_CTRL, 32'h40f);
		overTemp[0] <= 1'b1;
		cycles(3);
		sw(4'he);
		overTemp[0] <= 1'b0;
		cycles(60);
		sw(4'he);
		check({31'h0, pinOe}, 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[0]}, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h40e);
		bus(1'b1, ADDR_CTRL, 32'h40d);
		overTemp[1] <= 1'b1;
		cycles(3);
		sw(4'hd);
		check({31'h0, pinOe}, 32'h1);
		overTemp[1] <= 1'b0;
		cycles(3);
		check({31'h0, pinOe}, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[1]}, 32'h1);
		$display("end overtemperature");
		bus(1'b1, ADDR_CTRL, 32'h00f);
		loadCurrent[2] <= 8'hff;
		cycles(3);
		sw(4'hb);
		loadCurrent[2] <= 8'h0;
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[6]}, 32'h1);
		cycles(70);
		sw(4'hf);
		bus(1'b0, ADDR_RETRY, 32'h0);
		check({27'h0, rd[14:10]}, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h40f);
		bus(1'b1, ADDR_CTRL, 32'h00f);
		bus(1'b0, ADDR_RETRY, 32'h0);
		check(rd, 32'h0);
		severeShort[3] <= 1'b1;
		cycles(3);
		sw(4'h7);
		severeShort[3] <= 1'b0;
		cycles(70);
		sw(4'h7);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[11]}, 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[11]}, 32'h0);
		supplyPor <= 1'b1;
		cycles(2);
		supplyPor <= 1'b0;
		cycles(3);
		sw(4'hf);
		$display("end latches");
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, ADDR_OCCFG, 32'(s) << OCCFG_DCSEL_LSB);
			bus(1'b1, ADDR_CTRL, 32'h006);
			bus(1'b1, ADDR_CTRL, 32'h00f);
			cycles(50);
			loadCurrent[0] <= DC_LEVELS[s] - 8'h01;
			cycles(3);
			sw(4'hf);
			loadCurrent[0] <= DC_LEVELS[s];
			cycles(3);
			sw(4'he);
			loadCurrent[0] <= 8'h0;
		end
		bus(1'b1, ADDR_OCCFG, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h000);
		bus(1'b1, ADDR_CTRL, 32'h00f);
		$display("end dc levels");
		bus(1'b1, ADDR_CTRL, 32'h00e);
		loadCurrent[0] <= 8'ha0;
		bus(1'b1, ADDR_CTRL, 32'h0002000f);
		cycles(3);
		sw(4'he);
		bus(1'b1, ADDR_CTRL, 32'h00e);
		bus(1'b1, ADDR_CTRL, 32'h00f);
		cycles(2);
		sw(4'hf);
		loadCurrent[0] <= 8'h0;
		cycles(40);
		$display("end profiles");
		vpwrOverRecovered <= 1'b0;
		vpwrOverVoltage <= 1'b1;
		cycles(3);
		sw(4'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[STAT_OVF_BIT]}, 32'h1);
		vpwrOverVoltage <= 1'b0;
		vpwrOverRecovered <= 1'b1;
		cycles(3);
		sw(4'hf);
		vpwrUnder <= 1'b1;
		cycles(3);
		sw(4'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[STAT_UVF_BIT]}, 32'h1);
		vpwrUnder <= 1'b0;
		cycles(3);
		check({31'h0, pinOe}, 32'h1);
		check({31'h0, pinOut}, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[STAT_PIN_BIT]}, 32'h0);
		failSafe <= 1'b1;
		directInputs <= 4'h5;
		cycles(5);
		sw(4'h5);
		check({31'h0, normalMode}, 32'h0);
		vpwrOverRecovered <= 1'b0;
		vpwrOverVoltage <= 1'b1;
		cycles(3);
		sw(4'h0);
		$display("end supplies");
		testDone();
	end
endmodule
`default_nettype wire
